// file: uie_uart_events.sv
// uart event logic: flags, irq and dma requests, break and parity, register slave
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module uie_uart_events (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [23:0]           addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  input  wire logic                  bit_tick,
  input  wire logic                  serial_in,
  input  wire logic                  cts_in,
  output logic                       serial_out,
  input  wire logic [3:0]            router_irq_select,
  input  wire logic [1:0]            router_dma_select,
  output uie_pkg::uie_req_t          req,
  output uie_pkg::uie_route_t        route
);
  logic [7:0] ictrl_r, frs_r, mdsl1_r, baud_r, psr_r, ovr_r, mdsl2_r, spos_r;
  logic [7:0] tbuf_r, rbuf_r, rdata_r;
  logic       tx_empty_r, rx_full_r, rx_err_r, cts_chg_r;
  logic       frame_r, par_r, ovr_r_flag, brk_r, rb9_r;
  logic       rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r, cts_q_r;
  logic       tx_empty_q_r, rx_full_q_r, tx_dma_r, rx_dma_r, serial_out_r;
  logic [8:0] tx_shift_r, rx_shift_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic       tx_par_r, rx_perr_r;
  uie_pkg::uie_tx_st_t tx_st_r;
  uie_pkg::uie_rx_st_t rx_st_r;

  function automatic logic [3:0] frame_bits(input logic [1:0] fmt);
    unique case (fmt)
      uie_pkg::FMT_7: frame_bits = uie_pkg::BITS_7;
      uie_pkg::FMT_9: frame_bits = uie_pkg::BITS_9;
      default:        frame_bits = uie_pkg::BITS_8;
    endcase
  endfunction : frame_bits

  // parity bit over the low n bits of a character
  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic [1:0] sel);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    parity_of = (sel == uie_pkg::PSEL_ODD) ? ~p : p;
  endfunction : parity_of

  logic [1:0] fmt, psel;
  logic [3:0] nbits;
  logic       par_on, stop2, loop_en, atn_en, brk_en, tx_dma_en, rx_dma_en;
  assign fmt       = frs_r[uie_pkg::FR_FMT_LO +: 2];
  assign psel      = frs_r[uie_pkg::FR_PSEL_LO +: 2];
  assign stop2     = frs_r[uie_pkg::FR_STOP2];
  assign nbits     = frame_bits(fmt);
  assign loop_en   = mdsl1_r[uie_pkg::MD_LOOP];
  assign atn_en    = mdsl1_r[uie_pkg::MD_ATN];
  assign brk_en    = mdsl1_r[uie_pkg::MD_BRK];
  assign tx_dma_en = mdsl1_r[uie_pkg::MD_TX_DMA];
  assign rx_dma_en = mdsl1_r[uie_pkg::MD_RX_DMA];
  // parity only for 7/8 bit normal frames with a real odd/even choice
  assign par_on = frs_r[uie_pkg::FR_PEN] && (fmt != uie_pkg::FMT_9) && !loop_en && !atn_en
                  && (psel == uie_pkg::PSEL_ODD || psel == uie_pkg::PSEL_EVEN);

  // register strobes
  logic wr_tbuf, rd_rbuf, rd_ictrl, rd_stat;
  assign wr_tbuf  = ce && wr && (addr == uie_pkg::OFF_TBUF);
  assign rd_rbuf  = ce && rd && (addr == uie_pkg::OFF_RBUF);
  assign rd_ictrl = ce && rd && (addr == uie_pkg::OFF_ICTRL);
  assign rd_stat  = ce && rd && (addr == uie_pkg::OFF_STAT);

  // pin synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      cts_s1_r <= 1'b0;
      cts_s2_r <= 1'b0;
      cts_q_r  <= 1'b0;
    end else if (ce) begin
      rx_s1_r  <= serial_in;
      rx_s2_r  <= rx_s1_r;
      cts_s1_r <= cts_in;
      cts_s2_r <= cts_s1_r;
      cts_q_r  <= cts_s2_r;
    end
  end

  // software registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ictrl_r <= uie_pkg::REG_RST;
      frs_r   <= uie_pkg::REG_RST;
      baud_r  <= uie_pkg::REG_RST;
      psr_r   <= uie_pkg::REG_RST;
      ovr_r   <= uie_pkg::REG_RST;
      mdsl2_r <= uie_pkg::REG_RST;
      spos_r  <= uie_pkg::REG_RST;
      tbuf_r  <= uie_pkg::REG_RST;
    end else if (ce && wr) begin
      unique case (addr)
        uie_pkg::OFF_TBUF:  tbuf_r  <= wdata;
        uie_pkg::OFF_ICTRL: ictrl_r <= wdata;
        uie_pkg::OFF_FRS:   frs_r   <= wdata;
        uie_pkg::OFF_BAUD:  baud_r  <= wdata;
        uie_pkg::OFF_PSR:   psr_r   <= wdata;
        uie_pkg::OFF_OVR:   ovr_r   <= wdata;
        uie_pkg::OFF_MDSL2: mdsl2_r <= wdata;
        uie_pkg::OFF_SPOS:  spos_r  <= wdata;
        default: ;
      endcase
    end
  end

  // transmitter
  logic tx_load, tx_line;
  assign tx_load = ce && (tx_st_r == uie_pkg::TX_IDLE) && !tx_empty_r;
  always_comb begin
    unique case (tx_st_r)
      // start bit stays at idle level until the first tick so it spans a whole bit time
      uie_pkg::TX_START: tx_line = (tx_cnt_r == 4'h0);
      uie_pkg::TX_DATA:  tx_line = tx_shift_r[0];
      uie_pkg::TX_PAR:   tx_line = tx_par_r;
      default:           tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_st_r    <= uie_pkg::TX_IDLE;
      tx_shift_r <= 9'h1FF;
      tx_cnt_r   <= 4'h0;
      tx_par_r   <= 1'b0;
    end else if (tx_load) begin
      tx_shift_r <= {frs_r[uie_pkg::FR_XB9], tbuf_r};
      tx_par_r   <= parity_of({frs_r[uie_pkg::FR_XB9], tbuf_r}, nbits, psel);
      tx_cnt_r   <= 4'h0;
      tx_st_r    <= uie_pkg::TX_START;
    end else if (ce && bit_tick) begin
      unique case (tx_st_r)
        uie_pkg::TX_IDLE: ;
        uie_pkg::TX_START: begin
          if (tx_cnt_r == 4'h0) begin
            tx_cnt_r <= 4'h1;
          end else begin
            tx_st_r  <= uie_pkg::TX_DATA;
            tx_cnt_r <= 4'h0;
          end
        end
        uie_pkg::TX_DATA: begin
          tx_shift_r <= {1'b1, tx_shift_r[8:1]};
          tx_cnt_r   <= tx_cnt_r + 4'h1;
          if (tx_cnt_r == nbits - 4'h1) begin
            tx_st_r  <= par_on ? uie_pkg::TX_PAR : uie_pkg::TX_STOP;
            tx_cnt_r <= 4'h0;
          end
        end
        uie_pkg::TX_PAR: tx_st_r <= uie_pkg::TX_STOP;
        uie_pkg::TX_STOP: begin
          if (stop2 && tx_cnt_r == 4'h0) begin
            tx_cnt_r <= 4'h1;
          end else begin
            tx_st_r <= uie_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_out_r <= 1'b1;
    end else if (ce) begin
      serial_out_r <= brk_en ? 1'b0 : tx_line;
    end
  end

  // transmit empty: buffer write clears it, load into shifter sets it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_empty_r <= 1'b1;
    end else if (wr_tbuf) begin
      tx_empty_r <= 1'b0;
    end else if (tx_load) begin
      tx_empty_r <= 1'b1;
    end
  end

  // receiver
  logic rx_bit, rx_stop_tick, rx_keep, rx_accept, frame_set, par_set, ovr_set, brk_set, err_set;
  assign rx_bit       = loop_en ? tx_line : rx_s2_r;
  assign rx_stop_tick = ce && bit_tick && (rx_st_r == uie_pkg::RX_STOP);
  assign rx_keep      = !atn_en || rx_shift_r[8];
  assign rx_accept    = rx_stop_tick && rx_keep;
  assign frame_set    = rx_accept && !rx_bit;
  assign par_set      = rx_accept && rx_perr_r;
  assign ovr_set      = rx_accept && rx_full_r && !rd_rbuf;
  assign brk_set      = ce && bit_tick && (rx_st_r == uie_pkg::RX_BRK) && !rx_bit
                        && (rx_cnt_r == uie_pkg::BREAK_BITS - 4'h1);
  assign err_set      = frame_set || par_set || ovr_set || brk_set;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_st_r    <= uie_pkg::RX_IDLE;
      rx_shift_r <= 9'h000;
      rx_cnt_r   <= 4'h0;
      rx_perr_r  <= 1'b0;
    end else if (ce && bit_tick) begin
      unique case (rx_st_r)
        uie_pkg::RX_IDLE: begin
          if (!rx_bit) begin
            rx_st_r    <= uie_pkg::RX_DATA;
            rx_shift_r <= 9'h000;
            rx_cnt_r   <= 4'h0;
            rx_perr_r  <= 1'b0;
          end
        end
        uie_pkg::RX_DATA: begin
          rx_shift_r[rx_cnt_r] <= rx_bit;
          rx_cnt_r             <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == nbits - 4'h1) begin
            rx_st_r <= par_on ? uie_pkg::RX_PAR : uie_pkg::RX_STOP;
          end
        end
        uie_pkg::RX_PAR: begin
          rx_perr_r <= (rx_bit != parity_of(rx_shift_r, nbits, psel));
          rx_st_r   <= uie_pkg::RX_STOP;
        end
        uie_pkg::RX_STOP: begin
          rx_cnt_r <= 4'h0;
          rx_st_r  <= rx_bit ? uie_pkg::RX_IDLE : uie_pkg::RX_BRK;
        end
        uie_pkg::RX_BRK: begin
          if (rx_bit) begin
            rx_st_r <= uie_pkg::RX_IDLE;
          end else if (rx_cnt_r != uie_pkg::BREAK_BITS) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // receive buffer copy and attention auto-clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rbuf_r <= uie_pkg::REG_RST;
      rb9_r  <= 1'b0;
    end else if (rx_accept) begin
      rbuf_r <= rx_shift_r[7:0];
      rb9_r  <= rx_shift_r[8];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdsl1_r <= uie_pkg::REG_RST;
    end else if (ce && wr && addr == uie_pkg::OFF_MDSL1) begin
      mdsl1_r <= wdata;
    end else if (rx_accept && atn_en) begin
      mdsl1_r[uie_pkg::MD_ATN] <= 1'b0;
    end
  end

  // receive full: set on copy wins over a read in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_full_r <= 1'b0;
    end else if (rx_accept) begin
      rx_full_r <= 1'b1;
    end else if (rd_rbuf) begin
      rx_full_r <= 1'b0;
    end
  end

  // error flags: status read clears, a new error wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_err_r   <= 1'b0;
      frame_r    <= 1'b0;
      par_r      <= 1'b0;
      ovr_r_flag <= 1'b0;
      brk_r      <= 1'b0;
    end else if (ce) begin
      rx_err_r   <= err_set   || (rx_err_r   && !rd_stat);
      frame_r    <= frame_set || (frame_r    && !rd_stat);
      par_r      <= par_set   || (par_r      && !rd_stat);
      ovr_r_flag <= ovr_set   || (ovr_r_flag && !rd_stat);
      brk_r      <= brk_set   || (brk_r      && !rd_stat);
    end
  end

  // clear-to-send change: control read clears, a new edge wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cts_chg_r <= 1'b0;
    end else if (ce) begin
      cts_chg_r <= (cts_s2_r != cts_q_r) || (cts_chg_r && !rd_ictrl);
    end
  end

  // dma requests on flag rising edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_empty_q_r <= 1'b1;
      rx_full_q_r  <= 1'b0;
      tx_dma_r     <= 1'b0;
      rx_dma_r     <= 1'b0;
    end else if (ce) begin
      tx_empty_q_r <= tx_empty_r;
      rx_full_q_r  <= rx_full_r;
      tx_dma_r     <= tx_dma_en && tx_empty_r && !tx_empty_q_r;
      rx_dma_r     <= rx_dma_en && rx_full_r && !rx_full_q_r;
    end
  end

  // interrupt levels
  logic tx_irq, rx_irq, flow_irq;
  assign tx_irq   = tx_empty_r && ictrl_r[uie_pkg::IC_TX_IE] && !tx_dma_en;
  assign rx_irq   = (rx_full_r && ictrl_r[uie_pkg::IC_RX_IE] && !rx_dma_en)
                    || (rx_err_r && ictrl_r[uie_pkg::IC_ERR_IE]);
  assign flow_irq = cts_chg_r && ictrl_r[uie_pkg::IC_FLOW_IE];

  always_comb begin
    req.tx_irq   = tx_irq;
    req.rx_irq   = rx_irq;
    req.flow_irq = flow_irq;
    req.tx_dma   = tx_dma_r;
    req.rx_dma   = rx_dma_r;
    route.cpu_irq12_tx = tx_irq && !router_irq_select[uie_pkg::RT_IRQ_TX];
    route.cpu_irq13_rx = rx_irq && !router_irq_select[uie_pkg::RT_IRQ_RX];
    route.dsp_tx_irq   = tx_irq && router_irq_select[uie_pkg::RT_IRQ_TX];
    route.dsp_rx_irq   = rx_irq && router_irq_select[uie_pkg::RT_IRQ_RX];
    route.cpu_dma0_rx  = rx_dma_r && !router_dma_select[uie_pkg::RT_DMA_RX];
    route.cpu_dma1_tx  = tx_dma_r && !router_dma_select[uie_pkg::RT_DMA_TX];
    route.dsp_rx_dma   = rx_dma_r && router_dma_select[uie_pkg::RT_DMA_RX];
    route.dsp_tx_dma   = tx_dma_r && router_dma_select[uie_pkg::RT_DMA_TX];
  end

  // read data, valid only in the cycle after the strobe
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (addr)
      uie_pkg::OFF_RBUF: rd_val = rbuf_r;
      uie_pkg::OFF_ICTRL: begin
        rd_val = ictrl_r;
        rd_val[uie_pkg::IC_TX_EMPTY] = tx_empty_r;
        rd_val[uie_pkg::IC_RX_FULL]  = rx_full_r;
        rd_val[uie_pkg::IC_CTS_CHG]  = cts_chg_r;
        rd_val[uie_pkg::IC_CTS_LVL]  = cts_s2_r;
      end
      uie_pkg::OFF_STAT: begin
        rd_val[uie_pkg::ST_FRAME] = frame_r;
        rd_val[uie_pkg::ST_PAR]   = par_r;
        rd_val[uie_pkg::ST_OVR]   = ovr_r_flag;
        rd_val[uie_pkg::ST_ERR]   = rx_err_r;
        rd_val[uie_pkg::ST_BRK]   = brk_r;
        rd_val[uie_pkg::ST_RB9]   = rb9_r;
        rd_val[uie_pkg::ST_BUSY]  = (tx_st_r != uie_pkg::TX_IDLE) || !tx_empty_r;
      end
      uie_pkg::OFF_FRS:   rd_val = frs_r;
      uie_pkg::OFF_MDSL1: rd_val = mdsl1_r;
      uie_pkg::OFF_BAUD:  rd_val = baud_r;
      uie_pkg::OFF_PSR:   rd_val = psr_r;
      uie_pkg::OFF_OVR:   rd_val = ovr_r;
      uie_pkg::OFF_MDSL2: rd_val = mdsl2_r;
      uie_pkg::OFF_SPOS:  rd_val = spos_r;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= rd ? rd_val : 8'h00;
    end
  end

  assign rdata      = rdata_r;
  assign serial_out = serial_out_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_tbuf_write;
    wr_tbuf ##1 ce;
  endsequence

  sequence s_empty_rise;
    ce && tx_dma_en && tx_empty_r && !tx_empty_q_r;
  endsequence

  a_tbuf_clears_irq: assert property (s_tbuf_write |-> !req.tx_irq)
    else $error("tx irq still high after buffer write");
  a_txdma_masks_irq: assert property (tx_dma_en |-> !req.tx_irq)
    else $error("tx irq raised with tx dma enabled");
  a_txdma_pulse: assert property (s_empty_rise |=> req.tx_dma ##1 (!req.tx_dma || !$past(ce)))
    else $error("tx dma request not a single pulse");
  a_rxdma_once: assert property ((ce && req.rx_dma) |=> !req.rx_dma)
    else $error("rx dma request longer than one cycle");
  a_rbuf_read_clear: assert property ((rd_rbuf && !rx_accept) |=> !rx_full_r)
    else $error("rx full not cleared by buffer read");
  a_stat_read_clear: assert property ((rd_stat && !err_set) |=> !rx_err_r && (!req.rx_irq || rx_full_r))
    else $error("rx error not cleared by status read");
  a_cts_read_clear: assert property ((rd_ictrl && cts_s2_r == cts_q_r) |=> !req.flow_irq)
    else $error("flow irq not cleared by control read");
  a_break_holds_low: assert property ((ce && brk_en) [*2] |-> !serial_out)
    else $error("serial out not low during break");
  a_break_detect: assert property (brk_set |=> brk_r && rx_err_r)
    else $error("break not flagged after ten low bits");
  a_parity_nine_off: assert property ((fmt == uie_pkg::FMT_9 || loop_en || atn_en) |-> !par_on)
    else $error("parity active in a format that forbids it");
  a_route_exclusive: assert property (!(route.cpu_irq12_tx && route.dsp_tx_irq))
    else $error("tx irq routed to both controllers");
endmodule : uie_uart_events
`default_nettype wire

// file: uie_pkg.sv
// constants, types and register layout for the uart event block
// Contract
// - four interrupt sources, each with enable
// - tx irq equals empty and enable
// - tx buffer write clears empty flag
// - rx irq while full and enabled
// - rx buffer read clears full flag
// - rx irq also on error with enable
// - status read clears error flag
// - flow irq while cts change enabled
// - interrupt control read clears cts change
// - port3 irqs routed on channels 2,3
// - cpu irq lines 12 tx, 13 rx
// - tx dma pulse on empty rising
// - tx dma enable masks tx irq
// - rx dma pulse on full rising
// - rx dma masks full irq, not error
// - both dma directions usable together
// - port3 dma routed on channels 0,1
// - break bit holds serial output low
// - break after 10 low bit times; code flags it after a low stop bit and 10 further low bit times
// - parity only 7/8 bit, normal mode
// - parity enable and select in frame
// - empty set on shift register load
// - full set on buffer copy
package uie_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 8;

  localparam logic [23:0] OFF_TBUF  = 24'hFF9400;
  localparam logic [23:0] OFF_RBUF  = 24'hFF9404;
  localparam logic [23:0] OFF_ICTRL = 24'hFF9408;
  localparam logic [23:0] OFF_STAT  = 24'hFF940C;
  localparam logic [23:0] OFF_FRS   = 24'hFF9410;
  localparam logic [23:0] OFF_MDSL1 = 24'hFF9414;
  localparam logic [23:0] OFF_BAUD  = 24'hFF9418;
  localparam logic [23:0] OFF_PSR   = 24'hFF941C;
  localparam logic [23:0] OFF_OVR   = 24'hFF9420;
  localparam logic [23:0] OFF_MDSL2 = 24'hFF9424;
  localparam logic [23:0] OFF_SPOS  = 24'hFF9428;

  // interrupt_control fields
  localparam int unsigned IC_TX_EMPTY = 0;
  localparam int unsigned IC_RX_FULL  = 1;
  localparam int unsigned IC_RX_IE    = 2;
  localparam int unsigned IC_TX_IE    = 3;
  localparam int unsigned IC_CTS_CHG  = 4;
  localparam int unsigned IC_FLOW_IE  = 5;
  localparam int unsigned IC_ERR_IE   = 6;
  localparam int unsigned IC_CTS_LVL  = 7;
  // line_status fields
  localparam int unsigned ST_FRAME = 0;
  localparam int unsigned ST_PAR   = 1;
  localparam int unsigned ST_OVR   = 2;
  localparam int unsigned ST_ERR   = 3;
  localparam int unsigned ST_BRK   = 4;
  localparam int unsigned ST_RB9   = 5;
  localparam int unsigned ST_BUSY  = 6;
  // frame_select fields
  localparam int unsigned FR_FMT_LO = 0;
  localparam int unsigned FR_STOP2  = 2;
  localparam int unsigned FR_XB9    = 3;
  localparam int unsigned FR_PSEL_LO = 4;
  localparam int unsigned FR_PEN    = 6;
  // mode_select_one fields
  localparam int unsigned MD_TX_DMA = 0;
  localparam int unsigned MD_RX_DMA = 1;
  localparam int unsigned MD_BRK    = 2;
  localparam int unsigned MD_LOOP   = 3;
  localparam int unsigned MD_ATN    = 4;

  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_7 = 2'h1;
  localparam logic [1:0] FMT_9 = 2'h2;
  localparam logic [1:0] PSEL_ODD  = 2'h0;
  localparam logic [1:0] PSEL_EVEN = 2'h1;

  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'hA;

  // router channel indices
  localparam int unsigned RT_IRQ_TX = 2;
  localparam int unsigned RT_IRQ_RX = 3;
  localparam int unsigned RT_DMA_RX = 0;
  localparam int unsigned RT_DMA_TX = 1;

  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] ICTRL_RST = 8'h01;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uie_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP, RX_BRK} uie_rx_st_t;

  typedef struct packed {
    logic tx_irq;
    logic rx_irq;
    logic flow_irq;
    logic tx_dma;
    logic rx_dma;
  } uie_req_t;

  typedef struct packed {
    logic cpu_irq12_tx;
    logic cpu_irq13_rx;
    logic dsp_tx_irq;
    logic dsp_rx_irq;
    logic cpu_dma0_rx;
    logic cpu_dma1_tx;
    logic dsp_rx_dma;
    logic dsp_tx_dma;
  } uie_route_t;
endpackage : uie_pkg

// file: uie_remote_model.sv
// remote serial transceiver model: 8-bit frame receiver, frame and break sender, cts driver
`timescale 1ns/100ps
`default_nettype none
module uie_remote_model #(
  parameter int BIT = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       serial_out,
  output var  logic       serial_in,
  output var  logic       cts_in,
  output var  logic       got,
  output var  logic [7:0] got_byte
);
  logic [8:0] fr;
  initial begin
    serial_in = 1'b1;
    cts_in    = 1'b0;
    got       = 1'b0;
    got_byte  = 8'h00;
  end
  // samples mid-bit; a frame with a low stop bit is dropped
  always begin
    @(negedge serial_out);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_sys);
      fr[i] = serial_out;
    end
    if (fr[8]) begin
      got_byte <= fr[7:0];
      got      <= 1'b1;
      @(posedge clk_sys);
      got      <= 1'b0;
    end
  end
  // low > 0 holds the line low for a whole frame plus that many bit times
  task automatic send(input logic [7:0] d, input int low);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in <= (low > 0) ? 1'b0 : f[i];
      repeat (BIT) @(posedge clk_sys);
    end
    repeat (low * BIT) @(posedge clk_sys);
    serial_in <= 1'b1;
    repeat (BIT) @(posedge clk_sys);
  endtask : send
  task automatic set_cts(input logic v);
    cts_in <= v;
  endtask : set_cts
endmodule : uie_remote_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the uart event block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                clk_sys;
  logic                rst;
  logic [23:0]         addr;
  logic [7:0]          wdata;
  logic                wr;
  logic                rd;
  logic [7:0]          rdata;
  logic                bit_tick;
  logic                serial_in;
  logic                cts_in;
  logic                serial_out;
  logic [3:0]          irq_sel;
  logic [1:0]          dma_sel;
  uie_pkg::uie_req_t   req;
  uie_pkg::uie_route_t route;
  logic                got;
  logic [7:0]          got_byte;
  logic [7:0]          rd_q[$];
  logic [7:0]          tx_q[$];
  logic                rd_d;
  int                  fails;
  int                  compares;
  int                  n_txd;
  int                  n_rxd;
  int                  tick_cnt;
  int                  n;
  int                  m;
  logic [7:0]          tf[4] = '{8'h51, 8'h41, 8'h60, 8'h4A};
  logic [7:0]          td[4] = '{8'h57, 8'h57, 8'h3C, 8'h3C};
  logic [7:0]          te[4] = '{8'hD7, 8'h57, 8'h3C, 8'h3C};

  uie_uart_events dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bit_tick(bit_tick), .serial_in(serial_in), .cts_in(cts_in), .serial_out(serial_out),
    .router_irq_select(irq_sel), .router_dma_select(dma_sel), .req(req), .route(route));
  uie_remote_model #(.BIT(8)) partner_u (.clk_sys(clk_sys), .serial_out(serial_out), .serial_in(serial_in),
    .cts_in(cts_in), .got(got), .got_byte(got_byte));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic reg_wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [23:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd_q.push_back(exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
  endtask : reg_rd

  task automatic drain;
    for (int i = 0; i < 600 && tx_q.size() > 0; i++) @(posedge clk_sys);
    if (tx_q.size() > 0) begin
      fails++;
      summarize();
    end
  endtask : drain

  // one bit time every eight clocks; router selects change every cycle
  always @(posedge clk_sys) begin
    tick_cnt <= (tick_cnt == 7) ? 0 : tick_cnt + 1;
    bit_tick <= (tick_cnt == 7);
    irq_sel  <= 4'($urandom);
    dma_sel  <= 2'($urandom);
  end

  always @(posedge clk_sys) begin
    rd_d <= rd;
    if (rd_d) check("rdata", rdata, rd_q.pop_front());
    if (got) check("serial char", got_byte, tx_q.pop_front());
    check("route", route, {req.tx_irq & ~irq_sel[2], req.rx_irq & ~irq_sel[3], req.tx_irq & irq_sel[2],
      req.rx_irq & irq_sel[3], req.rx_dma & ~dma_sel[0], req.tx_dma & ~dma_sel[1], req.rx_dma & dma_sel[0],
      req.tx_dma & dma_sel[1]});
    if (req.tx_dma === 1'b1) n_txd++;
    if (req.rx_dma === 1'b1) n_rxd++;
  end

  initial begin
    rst = 1'b1;
    addr = 24'h000000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rd_d = 1'b0;
    bit_tick = 1'b0;
    irq_sel = 4'h0;
    dma_sel = 2'h0;
    fails = 0;
    compares = 0;
    n_txd = 0;
    n_rxd = 0;
    tick_cnt = 0;
    void'($urandom(32'h32A3));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(uie_pkg::OFF_ICTRL, 8'h01);
    reg_rd(24'hFF942C, 8'h00);
    reg_wr(uie_pkg::OFF_BAUD, 8'h5A);
    reg_rd(uie_pkg::OFF_BAUD, 8'h5A);
    reg_wr(uie_pkg::OFF_ICTRL, 8'h08);
    #1;
    check("tx_irq", 8'(req.tx_irq), 8'h01);
    tx_q.push_back(8'hA5);
    reg_wr(uie_pkg::OFF_TBUF, 8'hA5);
    #1;
    check("tx_irq", 8'(req.tx_irq), 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check("tx_irq", 8'(req.tx_irq), 8'h01);
    drain();
    // transmit dma on; frame formats with and without parity
    reg_wr(uie_pkg::OFF_MDSL1, 8'h01);
    #1;
    check("tx_irq", 8'(req.tx_irq), 8'h00);
    for (int k = 0; k < 4; k++) begin
      reg_wr(uie_pkg::OFF_FRS, tf[k]);
      n = n_txd;
      tx_q.push_back(te[k]);
      reg_wr(uie_pkg::OFF_TBUF, td[k]);
      drain();
      check("tx dma", 8'(n_txd - n), 8'h01);
    end
    reg_wr(uie_pkg::OFF_FRS, 8'h00);
    reg_wr(uie_pkg::OFF_MDSL1, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1;
    check("serial_out", 8'(serial_out), 8'h00);
    repeat (96) @(posedge clk_sys);
    check("serial_out", 8'(serial_out), 8'h00);
    reg_wr(uie_pkg::OFF_MDSL1, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check("serial_out", 8'(serial_out), 8'h01);
    reg_wr(uie_pkg::OFF_ICTRL, 8'h04);
    partner_u.send(8'hC3, 0);
    check("rx_irq", 8'(req.rx_irq), 8'h01);
    reg_rd(uie_pkg::OFF_RBUF, 8'hC3);
    #1;
    check("rx_irq", 8'(req.rx_irq), 8'h00);
    // full duplex with both dma requests, error irq kept enabled
    reg_wr(uie_pkg::OFF_ICTRL, 8'h44);
    reg_wr(uie_pkg::OFF_MDSL1, 8'h03);
    n = n_txd;
    m = n_rxd;
    tx_q.push_back(8'h96);
    reg_wr(uie_pkg::OFF_TBUF, 8'h96);
    partner_u.send(8'h69, 0);
    drain();
    check("rx_irq", 8'(req.rx_irq), 8'h00);
    check("rx dma", 8'(n_rxd - m), 8'h01);
    check("tx dma", 8'(n_txd - n), 8'h01);
    reg_rd(uie_pkg::OFF_RBUF, 8'h69);
    reg_wr(uie_pkg::OFF_MDSL1, 8'h00);
    reg_wr(uie_pkg::OFF_ICTRL, 8'h40);
    partner_u.send(8'h00, 11);
    check("rx_irq", 8'(req.rx_irq), 8'h01);
    reg_rd(uie_pkg::OFF_STAT, 8'h19);
    #1;
    check("rx_irq", 8'(req.rx_irq), 8'h00);
    reg_rd(uie_pkg::OFF_RBUF, 8'h00);
    reg_wr(uie_pkg::OFF_ICTRL, 8'h20);
    partner_u.set_cts(1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    check("flow_irq", 8'(req.flow_irq), 8'h01);
    reg_rd(uie_pkg::OFF_ICTRL, 8'hB1);
    #1;
    check("flow_irq", 8'(req.flow_irq), 8'h00);
    reg_rd(uie_pkg::OFF_ICTRL, 8'hA1);
    // loopback: the receiver takes the transmitted character, no parity
    reg_wr(uie_pkg::OFF_MDSL1, 8'h08);
    tx_q.push_back(8'h3C);
    reg_wr(uie_pkg::OFF_TBUF, 8'h3C);
    drain();
    repeat (16) @(posedge clk_sys);
    reg_rd(uie_pkg::OFF_RBUF, 8'h3C);
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
